// ### src/cfg_ctl_pkg.sv
// Constants, mode encodings and carrier types for the configuration pins.
// Assumes a 50 MHz system clock and pins sampled through synchronisers.
package cfg_ctl_pkg;

	// ==========================================================
	// Clock and timing
	localparam int MCLK_NS = 20;
	localparam int CLEAR_TIME_NS = 1000;
	localparam int CLEAR_CYC = (CLEAR_TIME_NS + MCLK_NS - 1) / MCLK_NS;
	localparam int CLEAR_W = 6;
	localparam logic [CLEAR_W-1:0] CLEAR_LAST = CLEAR_W'(CLEAR_CYC - 1);
	localparam int CONFIG_CLOCK_HALF_NS = 80;
	localparam int CONFIG_CLOCK_HALF_CYC = (CONFIG_CLOCK_HALF_NS + MCLK_NS - 1) / MCLK_NS;
	localparam int DIV_W = 3;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(CONFIG_CLOCK_HALF_CYC - 1);

	// ==========================================================
	// Readback geometry
	localparam int RB_WORD_W = 32;
	localparam int RB_BIT_W = 5;
	localparam logic [RB_BIT_W-1:0] RB_BIT_LAST = RB_BIT_W'(RB_WORD_W - 1);
	localparam int FRAME_W = 8;
	localparam logic [FRAME_W-1:0] FRAME_FIRST = 8'h00;
	localparam logic [FRAME_W-1:0] FRAME_LAST = 8'hFF;

	// ==========================================================
	// Configuration mode encodings on the four mode inputs
	localparam int MODE_W = 4;
	localparam logic [MODE_W-1:0] MODE_MASTER_SER = 4'h0;
	localparam logic [MODE_W-1:0] MODE_MASTER_PAR = 4'h1;
	localparam logic [MODE_W-1:0] MODE_ASYNC_PERIPH = 4'h2;
	localparam logic [MODE_W-1:0] MODE_SYNC_PERIPH = 4'h3;
	localparam logic [MODE_W-1:0] MODE_SLAVE_SER = 4'h4;
	localparam logic [MODE_W-1:0] MODE_SLAVE_PAR = 4'h5;
	localparam logic [MODE_W-1:0] MODE_SYSBUS = 4'h6;
	localparam logic [MODE_W-1:0] MODE_JTAG = 4'h7;
	localparam logic [MODE_W-1:0] MODE_RESET = 4'hF;

	// ==========================================================
	// Synchroniser lanes and their idle levels (pull-ups on all)
	localparam int PIN_W = 7;
	localparam int P_CONFIG_CLOCK = 0;
	localparam int P_DIN = 1;
	localparam int P_RDCFG = 2;
	localparam int P_RESET = 3;
	localparam int P_PROG = 4;
	localparam int P_DONE = 5;
	localparam int P_INIT = 6;
	localparam logic [PIN_W-1:0] PIN_IDLE = 7'h7F;

	// ==========================================================
	// Bitstream options, held stable by the loader
	typedef struct packed {
		logic readback_en;
		logic tsall_after;
		logic reset_direct;
		logic bscan_used;
		logic host_port_used;
		logic daisy_lead;
		logic pll_used;
	} cfg_opts_t;

	// Open-drain or two-way pin drive
	typedef struct packed {
		logic out;
		logic oe;
	} pin_drive_t;

	typedef enum logic [2:0] {
		ST_CLEAR, ST_WAIT, ST_LOAD, ST_START, ST_USER
	} cfg_state_t;

endpackage : cfg_ctl_pkg

// ### src/cfg_pin_ctl.sv
// Control logic behind the dedicated configuration pins.
// Assumes a loader core supplies done/error, readback words and options.
`timescale 1ns/1ns

module cfg_pin_ctl (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rstn,
	// Raw configuration pins
	input wire logic i_reset_pin,
	input wire logic i_program_restart_n,
	input wire logic i_rd_cfg,
	input wire logic i_din,
	input wire logic [cfg_ctl_pkg::MODE_W-1:0] i_mode_sel,
	input wire logic i_config_clock,
	input wire logic i_done,
	input wire logic i_init,
	// Loader core and fabric
	input wire cfg_ctl_pkg::cfg_opts_t i_opts,
	input wire logic i_load_done,
	input wire logic i_load_error,
	input wire logic [cfg_ctl_pkg::RB_WORD_W-1:0] i_rb_word,
	input wire logic i_tdo,
	input wire logic i_host_irq,
	// Two-way and open-drain pin drives
	output logic o_config_clock,
	output logic o_config_clock_oe,
	output logic o_done,
	output logic o_done_oe,
	output logic o_init,
	output logic o_init_oe,
	// Status and control towards the fabric
	output logic o_cfg_bit,
	output logic o_cfg_bit_strobe,
	output logic [cfg_ctl_pkg::MODE_W-1:0] o_mode,
	output logic o_configured,
	output logic o_logic_cell_reset_n,
	output logic o_bscan_reset_n,
	output logic o_all_io_tristate,
	output logic o_pll_pin_pullup,
	output logic o_pll_pin_user,
	output logic o_rb_active,
	output logic [cfg_ctl_pkg::FRAME_W-1:0] o_rb_frame_addr,
	output logic o_readback_data,
	output logic o_irq_n
);

	// ==========================================================
	// Mode decoding
	function automatic logic drives_clock(
		input logic [cfg_ctl_pkg::MODE_W-1:0] m, input logic lead);
		drives_clock = (m == cfg_ctl_pkg::MODE_MASTER_SER) ||
			(m == cfg_ctl_pkg::MODE_MASTER_PAR) ||
			(m == cfg_ctl_pkg::MODE_ASYNC_PERIPH) ||
			(lead && ((m == cfg_ctl_pkg::MODE_SYNC_PERIPH) ||
			(m == cfg_ctl_pkg::MODE_SYSBUS)));
	endfunction : drives_clock

	function automatic logic irq_mode(
		input logic [cfg_ctl_pkg::MODE_W-1:0] m);
		irq_mode = (m == cfg_ctl_pkg::MODE_JTAG) ||
			(m == cfg_ctl_pkg::MODE_SLAVE_SER) ||
			(m == cfg_ctl_pkg::MODE_SLAVE_PAR) ||
			(m == cfg_ctl_pkg::MODE_MASTER_SER) ||
			(m == cfg_ctl_pkg::MODE_MASTER_PAR) ||
			(m == cfg_ctl_pkg::MODE_ASYNC_PERIPH);
	endfunction : irq_mode

	// ==========================================================
	// Pin synchronisers
	logic [cfg_ctl_pkg::PIN_W-1:0] pin_raw;
	logic [cfg_ctl_pkg::PIN_W-1:0] pin_lvl;
	logic [cfg_ctl_pkg::PIN_W-1:0] pin_rise;
	logic [cfg_ctl_pkg::PIN_W-1:0] pin_fall;
	logic [cfg_ctl_pkg::MODE_W-1:0] mode_meta;
	logic [cfg_ctl_pkg::MODE_W-1:0] mode_sync;

	assign pin_raw = {i_init, i_done, i_program_restart_n, i_reset_pin,
		i_rd_cfg, i_din, i_config_clock};

	pin_sync #(.WIDTH(cfg_ctl_pkg::PIN_W), .IDLE(cfg_ctl_pkg::PIN_IDLE))
		u_sync (
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.i_pin(pin_raw),
		.o_level(pin_lvl),
		.o_rise(pin_rise),
		.o_fall(pin_fall)
	);

	// Mode straps are static, so a plain two-flop bus is enough
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			mode_meta <= cfg_ctl_pkg::MODE_RESET;
			mode_sync <= cfg_ctl_pkg::MODE_RESET;
		end else begin
			mode_meta <= i_mode_sel;
			mode_sync <= mode_meta;
		end
	end

	// ==========================================================
	// Sequencer
	cfg_ctl_pkg::cfg_state_t state, next_state;
	logic [cfg_ctl_pkg::CLEAR_W-1:0] clear_cnt, next_clear_cnt;
	logic [cfg_ctl_pkg::MODE_W-1:0] mode, next_mode;
	logic cfg_err, next_cfg_err;
	logic in_cfg;
	logic user;

	assign in_cfg = (state != cfg_ctl_pkg::ST_USER);
	assign user = (state == cfg_ctl_pkg::ST_USER);

	// Restart requests win over every other transition
	always_comb begin
		next_state = state;
		next_clear_cnt = clear_cnt;
		next_mode = mode;
		next_cfg_err = cfg_err;
		case (state)
		cfg_ctl_pkg::ST_CLEAR: begin
			next_cfg_err = 1'b0;
			next_clear_cnt = clear_cnt + 1'b1;
			if (clear_cnt == cfg_ctl_pkg::CLEAR_LAST) begin
				next_state = cfg_ctl_pkg::ST_WAIT;
			end
		end
		cfg_ctl_pkg::ST_WAIT: begin
			// External low on init keeps us here
			if (pin_rise[cfg_ctl_pkg::P_INIT]) begin
				next_mode = mode_sync;
				next_state = cfg_ctl_pkg::ST_LOAD;
			end
		end
		cfg_ctl_pkg::ST_LOAD: begin
			if (i_load_error) begin
				next_cfg_err = 1'b1;
			end
			if (i_load_done) begin
				next_state = cfg_ctl_pkg::ST_START;
			end
		end
		cfg_ctl_pkg::ST_START: begin
			// Another device may still hold the shared pin low
			if (pin_lvl[cfg_ctl_pkg::P_DONE]) begin
				next_state = cfg_ctl_pkg::ST_USER;
			end
		end
		cfg_ctl_pkg::ST_USER: begin
			next_state = cfg_ctl_pkg::ST_USER;
		end
		default: begin
			next_state = cfg_ctl_pkg::ST_CLEAR;
		end
		endcase
		if (!pin_lvl[cfg_ctl_pkg::P_PROG] || (in_cfg &&
			state != cfg_ctl_pkg::ST_CLEAR &&
			!pin_lvl[cfg_ctl_pkg::P_RESET])) begin
			next_state = cfg_ctl_pkg::ST_CLEAR;
			next_clear_cnt = '0;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			state <= cfg_ctl_pkg::ST_CLEAR;
			clear_cnt <= '0;
			mode <= cfg_ctl_pkg::MODE_RESET;
			cfg_err <= 1'b0;
		end else begin
			state <= next_state;
			clear_cnt <= next_clear_cnt;
			mode <= next_mode;
			cfg_err <= next_cfg_err;
		end
	end

	// ==========================================================
	// Configuration clock and data strobe
	logic drive_clk;
	logic [cfg_ctl_pkg::DIV_W-1:0] div_cnt, next_div_cnt;
	logic clk_out, next_clk_out;
	logic bit_q, next_bit_q;
	logic strobe, next_strobe;
	logic clk_edge;

	assign drive_clk = (state == cfg_ctl_pkg::ST_LOAD) &&
		drives_clock(mode, i_opts.daisy_lead);
	// Own rising edge when driving, sampled edge otherwise
	assign clk_edge = drive_clk ?
		(div_cnt == cfg_ctl_pkg::DIV_LAST && !clk_out) :
		pin_rise[cfg_ctl_pkg::P_CONFIG_CLOCK];

	always_comb begin
		next_div_cnt = '0;
		next_clk_out = 1'b0;
		next_bit_q = bit_q;
		next_strobe = 1'b0;
		if (drive_clk) begin
			next_div_cnt = div_cnt + 1'b1;
			next_clk_out = clk_out;
			if (div_cnt == cfg_ctl_pkg::DIV_LAST) begin
				next_div_cnt = '0;
				next_clk_out = !clk_out;
			end
		end
		if (state == cfg_ctl_pkg::ST_LOAD && clk_edge) begin
			next_bit_q = pin_lvl[cfg_ctl_pkg::P_DIN];
			next_strobe = 1'b1;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			div_cnt <= '0;
			clk_out <= 1'b0;
			bit_q <= 1'b0;
			strobe <= 1'b0;
		end else begin
			div_cnt <= next_div_cnt;
			clk_out <= next_clk_out;
			bit_q <= next_bit_q;
			strobe <= next_strobe;
		end
	end

	// ==========================================================
	// Readback shifter
	logic rb_active, next_rb_active;
	logic rb_load, next_rb_load;
	logic [cfg_ctl_pkg::RB_WORD_W-1:0] rb_shift, next_rb_shift;
	logic [cfg_ctl_pkg::RB_BIT_W-1:0] rb_bit, next_rb_bit;
	logic [cfg_ctl_pkg::FRAME_W-1:0] rb_frame, next_rb_frame;

	// Word reload lags the address by a cycle; clock is far slower
	always_comb begin
		next_rb_active = rb_active;
		next_rb_load = 1'b0;
		next_rb_shift = rb_shift;
		next_rb_bit = rb_bit;
		next_rb_frame = rb_frame;
		if (rb_load) begin
			next_rb_shift = i_rb_word;
		end
		if (!user) begin
			next_rb_active = 1'b0;
		end else if (!rb_active) begin
			if (i_opts.readback_en && pin_fall[cfg_ctl_pkg::P_RDCFG]) begin
				next_rb_active = 1'b1;
				next_rb_frame = cfg_ctl_pkg::FRAME_FIRST;
				next_rb_bit = '0;
				next_rb_load = 1'b1;
			end
		end else if (pin_rise[cfg_ctl_pkg::P_CONFIG_CLOCK]) begin
			next_rb_shift = {rb_shift[cfg_ctl_pkg::RB_WORD_W-2:0], 1'b0};
			next_rb_bit = rb_bit + 1'b1;
			if (rb_bit == cfg_ctl_pkg::RB_BIT_LAST) begin
				if (rb_frame == cfg_ctl_pkg::FRAME_LAST) begin
					next_rb_active = 1'b0;
				end else begin
					next_rb_frame = rb_frame + 1'b1;
					next_rb_load = 1'b1;
				end
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			rb_active <= 1'b0;
			rb_load <= 1'b0;
			rb_shift <= '0;
			rb_bit <= '0;
			rb_frame <= cfg_ctl_pkg::FRAME_FIRST;
		end else begin
			rb_active <= next_rb_active;
			rb_load <= next_rb_load;
			rb_shift <= next_rb_shift;
			rb_bit <= next_rb_bit;
			rb_frame <= next_rb_frame;
		end
	end

	// ==========================================================
	// Registered pin and fabric outputs
	cfg_ctl_pkg::pin_drive_t next_done_drv, next_init_drv;
	logic next_tristate, next_lc_rst_n, next_rd_data, next_irq_n;

	always_comb begin
		// Open drain: only ever pulls low
		next_done_drv = '{out: 1'b0, oe: in_cfg &&
			state != cfg_ctl_pkg::ST_START};
		next_init_drv = '{out: 1'b0,
			oe: state == cfg_ctl_pkg::ST_CLEAR};
		next_tristate = !pin_lvl[cfg_ctl_pkg::P_RDCFG] &&
			(in_cfg || i_opts.tsall_after);
		next_lc_rst_n = !(user && i_opts.reset_direct &&
			!pin_lvl[cfg_ctl_pkg::P_RESET]);
		next_rd_data = i_opts.bscan_used ? i_tdo :
			rb_shift[cfg_ctl_pkg::RB_WORD_W-1];
		next_irq_n = 1'b1;
		if (user && i_opts.host_port_used) begin
			next_irq_n = !i_host_irq;
		end else if (in_cfg && irq_mode(mode)) begin
			next_irq_n = !cfg_err;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_done <= 1'b0;
			o_done_oe <= 1'b1;
			o_init <= 1'b0;
			o_init_oe <= 1'b1;
			o_all_io_tristate <= 1'b0;
			o_logic_cell_reset_n <= 1'b1;
			o_readback_data <= 1'b0;
			o_irq_n <= 1'b1;
		end else begin
			o_done <= next_done_drv.out;
			o_done_oe <= next_done_drv.oe;
			o_init <= next_init_drv.out;
			o_init_oe <= next_init_drv.oe;
			o_all_io_tristate <= next_tristate;
			o_logic_cell_reset_n <= next_lc_rst_n;
			o_readback_data <= next_rd_data;
			o_irq_n <= next_irq_n;
		end
	end

	// Direct views of internal state
	assign o_config_clock = clk_out;
	assign o_config_clock_oe = drive_clk;
	assign o_cfg_bit = bit_q;
	assign o_cfg_bit_strobe = strobe;
	assign o_mode = mode;
	assign o_configured = user;
	assign o_bscan_reset_n = pin_lvl[cfg_ctl_pkg::P_PROG];
	assign o_pll_pin_pullup = in_cfg;
	assign o_pll_pin_user = user && !i_opts.pll_used;
	assign o_rb_active = rb_active;
	assign o_rb_frame_addr = rb_frame;

	// ==========================================================
	// Checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rstn);

	a_reset_restart: assert property (
		(state == cfg_ctl_pkg::ST_LOAD && !pin_lvl[cfg_ctl_pkg::P_RESET])
		|=> state == cfg_ctl_pkg::ST_CLEAR)
		else $error("reset pin did not abandon the load");
	a_prog_restart: assert property (
		!pin_lvl[cfg_ctl_pkg::P_PROG] |-> !o_bscan_reset_n
		##1 state == cfg_ctl_pkg::ST_CLEAR)
		else $error("program low did not restart");
	a_clock_driven: assert property (
		(state == cfg_ctl_pkg::ST_LOAD &&
		mode == cfg_ctl_pkg::MODE_MASTER_SER) |-> o_config_clock_oe)
		else $error("master mode clock not driven");
	a_clock_input: assert property (
		(user || mode == cfg_ctl_pkg::MODE_SLAVE_SER) |->
		!o_config_clock_oe)
		else $error("clock driven in slave or readback");
	a_startup_hold: assert property (
		(state == cfg_ctl_pkg::ST_START && !pin_lvl[cfg_ctl_pkg::P_DONE]
		&& pin_lvl[cfg_ctl_pkg::P_PROG] && pin_lvl[cfg_ctl_pkg::P_RESET])
		|=> state == cfg_ctl_pkg::ST_START)
		else $error("start-up left while done low");
	a_done_release: assert property (
		$rose(state == cfg_ctl_pkg::ST_START) |=> !o_done_oe)
		else $error("done not released after load");
	a_mode_latch: assert property (
		(state == cfg_ctl_pkg::ST_WAIT && pin_rise[cfg_ctl_pkg::P_INIT]
		&& pin_lvl[cfg_ctl_pkg::P_PROG] && pin_lvl[cfg_ctl_pkg::P_RESET])
		|=> mode == $past(mode_sync))
		else $error("mode not latched on init rise");
	a_tristate_cfg: assert property (
		(in_cfg && !pin_lvl[cfg_ctl_pkg::P_RDCFG]) |=> o_all_io_tristate)
		else $error("trigger low did not float I/O");
	a_readback_start: assert property (
		(user && !rb_active && i_opts.readback_en &&
		pin_fall[cfg_ctl_pkg::P_RDCFG]) |=> rb_active &&
		o_rb_frame_addr == cfg_ctl_pkg::FRAME_FIRST)
		else $error("readback did not start at frame zero");
	a_init_clear: assert property (
		state == cfg_ctl_pkg::ST_CLEAR |-> ##1 (o_init_oe && !o_init)
		or ##1 (state != cfg_ctl_pkg::ST_CLEAR))
		else $error("init not held low while clearing");

endmodule : cfg_pin_ctl

// ### src/pin_sync.sv
// Two-flop synchronisers with edge detection for a vector of pins.
// Assumes the pins are asynchronous to i_mclk; edges come from stage two.
`timescale 1ns/1ns
module pin_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] IDLE = '0
) (
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rstn,
	// Raw pins
	input wire logic [WIDTH-1:0] i_pin,
	// Synchronised level and edges
	output logic [WIDTH-1:0] o_level,
	output logic [WIDTH-1:0] o_rise,
	output logic [WIDTH-1:0] o_fall
);

	// ==========================================================
	// Stages
	logic [WIDTH-1:0] meta;
	logic [WIDTH-1:0] sync;
	logic [WIDTH-1:0] prev;

	// Only stage two and later feed logic
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			meta <= IDLE;
			sync <= IDLE;
			prev <= IDLE;
		end else begin
			meta <= i_pin;
			sync <= meta;
			prev <= sync;
		end
	end

	// Edges against the previous settled sample
	assign o_level = sync;
	assign o_rise = sync & ~prev;
	assign o_fall = ~sync & prev;

endmodule : pin_sync

// ### verification/cfg_source.sv
// Behavioural model of the configuration source beside the pin block.
// Assumes open-drain init/done wires with pull-ups and a 160 ns link clock.
`timescale 1ns/1ns
module cfg_source (
	// Control from the bench
	input wire logic i_clk_run,
	input wire logic i_hold_init,
	input wire logic i_hold_done,
	// Pin drives from the device
	input wire logic i_clk_drv,
	input wire logic i_clk_oe,
	input wire logic i_init_oe,
	input wire logic i_done_oe,
	// Resolved wires
	output logic o_config_clock,
	output logic o_init,
	output logic o_done
);
	// ==========================================================
	// Source clock
	logic src_clk;

	// Runs only within frames, starts off the sampling edge
	initial begin
		src_clk = 1'b0;
		forever begin
			@(posedge i_clk_run);
			#85;
			while (i_clk_run) begin
				src_clk = 1'b1;
				#80;
				src_clk = 1'b0;
				#80;
			end
		end
	end

	// ==========================================================
	// Wire resolution, pull-ups win when nobody pulls low
	assign o_config_clock = i_clk_oe ? i_clk_drv : src_clk;
	assign o_init = !(i_init_oe || i_hold_init);
	assign o_done = !(i_done_oe || i_hold_done);
endmodule : cfg_source

// ### verification/testbench.sv
// Self-checking bench for the configuration pin control block.
// Assumes cfg_source models the far side; opts are static between steps.
`timescale 1ns/1ns
module testbench;
	// ==========================================================
	// Signals
	logic i_mclk, i_rstn, i_reset_pin, i_program_restart_n, i_rd_cfg;
	logic i_din, i_config_clock, i_done, i_init;
	logic [cfg_ctl_pkg::MODE_W-1:0] i_mode_sel;
	cfg_ctl_pkg::cfg_opts_t i_opts;
	logic i_load_done, i_load_error, i_tdo, i_host_irq;
	logic [cfg_ctl_pkg::RB_WORD_W-1:0] i_rb_word;
	logic o_config_clock, o_config_clock_oe, o_done, o_done_oe;
	logic o_init, o_init_oe, o_cfg_bit, o_cfg_bit_strobe, o_configured;
	logic [cfg_ctl_pkg::MODE_W-1:0] o_mode;
	logic o_logic_cell_reset_n, o_bscan_reset_n, o_all_io_tristate;
	logic o_pll_pin_pullup, o_pll_pin_user, o_rb_active;
	logic [cfg_ctl_pkg::FRAME_W-1:0] o_rb_frame_addr;
	logic o_readback_data, o_irq_n;
	logic clk_run, hold_init, hold_done;
	int err_count, num_checks;

	// ==========================================================
	// Instances
	cfg_pin_ctl i_dut (.i_mclk(i_mclk), .i_rstn(i_rstn),
		.i_reset_pin(i_reset_pin), .i_program_restart_n(i_program_restart_n),
		.i_rd_cfg(i_rd_cfg), .i_din(i_din), .i_mode_sel(i_mode_sel),
		.i_config_clock(i_config_clock), .i_done(i_done), .i_init(i_init),
		.i_opts(i_opts), .i_load_done(i_load_done),
		.i_load_error(i_load_error), .i_rb_word(i_rb_word), .i_tdo(i_tdo),
		.i_host_irq(i_host_irq), .o_config_clock(o_config_clock),
		.o_config_clock_oe(o_config_clock_oe), .o_done(o_done),
		.o_done_oe(o_done_oe), .o_init(o_init), .o_init_oe(o_init_oe),
		.o_cfg_bit(o_cfg_bit), .o_cfg_bit_strobe(o_cfg_bit_strobe),
		.o_mode(o_mode), .o_configured(o_configured),
		.o_logic_cell_reset_n(o_logic_cell_reset_n),
		.o_bscan_reset_n(o_bscan_reset_n),
		.o_all_io_tristate(o_all_io_tristate),
		.o_pll_pin_pullup(o_pll_pin_pullup), .o_pll_pin_user(o_pll_pin_user),
		.o_rb_active(o_rb_active), .o_rb_frame_addr(o_rb_frame_addr),
		.o_readback_data(o_readback_data), .o_irq_n(o_irq_n));

	cfg_source i_src (.i_clk_run(clk_run), .i_hold_init(hold_init),
		.i_hold_done(hold_done), .i_clk_drv(o_config_clock),
		.i_clk_oe(o_config_clock_oe), .i_init_oe(o_init_oe),
		.i_done_oe(o_done_oe), .o_config_clock(i_config_clock),
		.o_init(i_init), .o_done(i_done));

	// ==========================================================
	// Tasks
	task automatic cyc(input int n);
		repeat (n) @(posedge i_mclk);
	endtask : cyc

	// Lets the edge's register updates land before looking
	task automatic look(input int n);
		cyc(n);
		#1;
	endtask : look

	task automatic chk_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_bit

	task automatic chk_vec(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk_vec

	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : wrap_up

	// Bounded wait; a hang counts as a mismatch
	task automatic wait_until(ref logic s, input logic v, input int lim);
		#1;
		for (int i = 0; i < lim && s !== v; i++) look(1);
		if (s !== v) begin
			err_count++;
			$display("wait limit hit at %0t", $time);
			wrap_up();
		end
	endtask : wait_until

	// Bounded wait for the next rise of the link clock
	task automatic wait_config_clock_rise;
		int n;
		n = 0;
		while (i_config_clock !== 1'b0 && n < 400) begin
			#1;
			n++;
		end
		while (i_config_clock !== 1'b1 && n < 400) begin
			#1;
			n++;
		end
		if (i_config_clock !== 1'b1) begin
			err_count++;
			$display("clock wait limit hit at %0t", $time);
			wrap_up();
		end
	endtask : wait_config_clock_rise

	// Restart through the program pin, then wait past the init rise
	task automatic restart(input logic [3:0] m);
		cyc(1);
		i_program_restart_n <= 1'b0;
		i_load_error <= 1'b0;
		i_load_done <= 1'b0;
		i_mode_sel <= m;
		look(4);
		chk_bit(o_bscan_reset_n, 1'b0);
		chk_bit(o_init_oe, 1'b1);
		cyc(1);
		i_program_restart_n <= 1'b1;
		wait_until(o_init_oe, 1'b0, 100);
		look(6);
		chk_vec({4'h0, o_mode}, {4'h0, m});
	endtask : restart

	// ==========================================================
	// Clock
	initial begin
		i_mclk = 1'b0;
		forever #10 i_mclk = ~i_mclk;
	end

	// ==========================================================
	// Main sequence
	initial begin
		i_rstn = 1'b0;
		i_reset_pin = 1'b1;
		i_program_restart_n = 1'b1;
		i_rd_cfg = 1'b1;
		i_din = 1'b0;
		i_mode_sel = 4'h0;
		i_opts = '0;
		i_opts.pll_used = 1'b1;
		i_load_done = 1'b0;
		i_load_error = 1'b0;
		i_rb_word = 32'hA5C30F96;
		i_tdo = 1'b0;
		i_host_irq = 1'b0;
		clk_run = 1'b0;
		hold_init = 1'b1;
		hold_done = 1'b0;
		err_count = 0;
		num_checks = 0;
		look(2);
		chk_vec({4'h0, o_mode}, 8'h0F);
		chk_bit(o_irq_n, 1'b1);
		cyc(2);
		i_rstn <= 1'b1;
		// Init held low while clearing, then held off by the source
		look(40);
		chk_bit(o_init_oe, 1'b1);
		look(20);
		chk_bit(o_init_oe, 1'b0);
		chk_vec({4'h0, o_mode}, 8'h0F);
		cyc(1);
		hold_init <= 1'b0;
		i_din <= 1'b1;
		look(6);
		chk_vec({4'h0, o_mode}, 8'h00);
		chk_bit(o_config_clock_oe, 1'b1);
		chk_bit(o_pll_pin_pullup, 1'b1);
		chk_bit(o_done_oe, 1'b1);
		cyc(1);
		wait_until(o_cfg_bit_strobe, 1'b1, 40);
		chk_bit(o_cfg_bit, 1'b1);
		cyc(1);
		i_rd_cfg <= 1'b0;
		look(6);
		chk_bit(o_all_io_tristate, 1'b1);
		cyc(1);
		i_rd_cfg <= 1'b1;
		i_reset_pin <= 1'b0;
		look(5);
		chk_bit(o_init_oe, 1'b1);
		cyc(1);
		i_reset_pin <= 1'b1;
		$display("test load and restart done");

		// Start-up held off by an external low on done
		wait_until(o_init_oe, 1'b0, 100);
		cyc(6);
		hold_done <= 1'b1;
		i_load_done <= 1'b1;
		look(8);
		chk_bit(o_done_oe, 1'b0);
		chk_bit(o_configured, 1'b0);
		cyc(1);
		hold_done <= 1'b0;
		look(6);
		chk_bit(o_configured, 1'b1);
		chk_bit(o_pll_pin_user, 1'b0);
		chk_bit(o_pll_pin_pullup, 1'b0);
		$display("test start-up done");

		// User phase: trigger options, direct reset, host interrupt
		cyc(1);
		i_rd_cfg <= 1'b0;
		look(6);
		chk_bit(o_all_io_tristate, 1'b0);
		chk_bit(o_rb_active, 1'b0);
		cyc(1);
		i_opts.tsall_after <= 1'b1;
		look(3);
		chk_bit(o_all_io_tristate, 1'b1);
		cyc(1);
		i_rd_cfg <= 1'b1;
		i_opts.tsall_after <= 1'b0;
		i_opts.reset_direct <= 1'b1;
		i_reset_pin <= 1'b0;
		i_opts.host_port_used <= 1'b1;
		i_host_irq <= 1'b1;
		look(5);
		chk_bit(o_logic_cell_reset_n, 1'b0);
		chk_bit(o_configured, 1'b1);
		chk_bit(o_irq_n, 1'b0);
		cyc(1);
		i_reset_pin <= 1'b1;
		i_host_irq <= 1'b0;
		look(5);
		chk_bit(o_logic_cell_reset_n, 1'b1);
		chk_bit(o_irq_n, 1'b1);
		$display("test user controls done");

		// Readback from frame zero, clocked by the source
		cyc(1);
		i_opts.readback_en <= 1'b1;
		i_rd_cfg <= 1'b0;
		look(6);
		chk_bit(o_rb_active, 1'b1);
		chk_vec(o_rb_frame_addr, 8'h00);
		cyc(1);
		clk_run <= 1'b1;
		for (int k = 0; k < 33; k++) begin
			wait_config_clock_rise();
			if (k < 32) chk_bit(o_readback_data, i_rb_word[31-k]);
			else chk_vec(o_rb_frame_addr, 8'h01);
		end
		cyc(1);
		clk_run <= 1'b0;
		i_opts.bscan_used <= 1'b1;
		i_tdo <= 1'b1;
		look(3);
		chk_bit(o_readback_data, 1'b1);
		cyc(1);
		i_tdo <= 1'b0;
		look(3);
		chk_bit(o_readback_data, 1'b0);
		cyc(1);
		i_rd_cfg <= 1'b1;
		i_opts <= '0;
		look(1);
		chk_bit(o_pll_pin_user, 1'b1);
		$display("test readback done");

		// Slave serial: clock from the source, data from the bench
		restart(4'h4);
		chk_bit(o_config_clock_oe, 1'b0);
		cyc(1);
		clk_run <= 1'b1;
		i_din <= 1'b1;
		wait_until(o_cfg_bit_strobe, 1'b1, 40);
		chk_bit(o_cfg_bit, 1'b1);
		cyc(1);
		i_din <= 1'b0;
		look(12);
		wait_until(o_cfg_bit_strobe, 1'b1, 40);
		chk_bit(o_cfg_bit, 1'b0);
		cyc(1);
		clk_run <= 1'b0;
		$display("test slave load done");

		// Every mode as daisy lead: clock direction and error interrupt
		cyc(1);
		i_opts.daisy_lead <= 1'b1;
		for (int m = 0; m < 8; m++) begin
			restart(4'(m));
			chk_bit(o_config_clock_oe, !(m inside {4, 5, 7}));
			cyc(1);
			i_load_error <= 1'b1;
			look(4);
			chk_bit(o_irq_n, m == 3 || m == 6);
		end
		$display("test mode table done");
		wrap_up();
	end
endmodule : testbench
